// file: shared/tmr0_consts.svh
// Constants for the 8-bit timer/counter block: register indexes, field positions, reset values.
// Assumes a 32-bit AXI4-Lite register bus with 10 address bits and one clock domain.
//
// Notes on behaviour
// - One shared free-running 10-bit prescaler feeds all taps.
// - Prescaler taps divide by 8, 64, 256, 1024.
// - Select 0 halts; 1 every clock; 2-5 prescaled.
// - Select 6 counts pin falls, 7 counts rises.
// - Divided taps derive straight from the system clock.
// - Count pin synchronised on rising clock before edges.
// - Pin counts even while configured as an output.
// - Eight-bit up-counter, software reads and writes it.
// - After count write, counting resumes next cycle.
// - Control bits 7..3 read zero, not writable.
// - Overflow flag and enable in shared flag/mask registers.
`ifndef TMR0_CONSTS_SVH
`define TMR0_CONSTS_SVH

`define TMR0_ADDR_W       10
`define TMR0_DATA_W       32
`define TMR0_IDX_W        8
`define TMR0_CNT_IDX      8'h32
`define TMR0_CTRL_IDX     8'h33
`define TMR0_FLAG_IDX     8'h38
`define TMR0_MASK_IDX     8'h39

`define TMR0_CNT_W        8
`define TMR0_CTRL_W       3
`define TMR0_EVT_W        8
`define TMR0_OVF_BIT      0
`define TMR0_CNT_MAX      8'hff
`define TMR0_CNT_RST      8'h00
`define TMR0_CTRL_RST     3'h0
`define TMR0_EVT_RST      8'h00

`define TMR0_PRESC_W      10
`define TMR0_TAP8_BITS    3
`define TMR0_TAP64_BITS   6
`define TMR0_TAP256_BITS  8
`define TMR0_TAP1024_BITS 10

`define TMR0_RESP_OKAY    2'h0
`define TMR0_RESP_SLVERR  2'h2

`endif

// file: shared/tmr0_pkg.sv
// Types shared by the timer/counter design files.
// Assumes tmr0_consts.svh is compiled alongside.
`default_nettype none

package tmr0_pkg;

    typedef enum logic [2:0] {
        TMR0_CS_STOP     = 3'h0,
        TMR0_CS_CLK      = 3'h1,
        TMR0_CS_DIV8     = 3'h2,
        TMR0_CS_DIV64    = 3'h3,
        TMR0_CS_DIV256   = 3'h4,
        TMR0_CS_DIV1024  = 3'h5,
        TMR0_CS_PIN_FALL = 3'h6,
        TMR0_CS_PIN_RISE = 3'h7
    } tmr0_clksel_t;

    // One-cycle enable pulses from the shared prescaler.
    typedef struct packed {
        logic tap1024;
        logic tap256;
        logic tap64;
        logic tap8;
    } tmr0_taps_t;

endpackage : tmr0_pkg

`default_nettype wire

// file: verilog/tmr0_prescaler.sv
// Shared free-running prescaler producing divide-by enable pulses.
// Assumes every timer selects one tap itself; the counter never restarts except at reset.
`include "tmr0_consts.svh"
`default_nettype none

module tmr0_prescaler #(
    parameter int W = `TMR0_PRESC_W
) (
    // Clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_nrst,
    // Tap pulses
    output tmr0_pkg::tmr0_taps_t     o_taps
);
    import tmr0_pkg::*;

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    // Runs on the system clock itself, so every tap is a clean enable, not a derived clock.
    always_comb begin
        cnt_next = cnt_reg + {{(W-1){1'b0}}, 1'b1};
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // A tap fires when its low bits are all ones, once per period.
    always_comb begin
        o_taps.tap8    = &cnt_reg[`TMR0_TAP8_BITS-1:0];
        o_taps.tap64   = &cnt_reg[`TMR0_TAP64_BITS-1:0];
        o_taps.tap256  = &cnt_reg[`TMR0_TAP256_BITS-1:0];
        o_taps.tap1024 = &cnt_reg[`TMR0_TAP1024_BITS-1:0];
    end

endmodule : tmr0_prescaler

`default_nettype wire

// file: verilog/tmr0_top.sv
// 8-bit up-counting timer/counter with clock select, overflow flag and AXI4-Lite registers.
// Assumes the count pin is synchronous to i_clk and changes at most once per clock period.
//
// Register access over AXI4-Lite is this design's own decision.
`include "tmr0_consts.svh"
`default_nettype none

module tmr0_top (
    // Clock and reset
    input  wire logic                    i_clk,
    input  wire logic                    i_nrst,
    // AXI4-Lite write address
    input  wire logic                    i_s_axi_awvalid,
    output logic                         o_s_axi_awready,
    input  wire logic [`TMR0_ADDR_W-1:0] i_s_axi_awaddr,
    input  wire logic [2:0]              i_s_axi_awprot,
    // AXI4-Lite write data
    input  wire logic                    i_s_axi_wvalid,
    output logic                         o_s_axi_wready,
    input  wire logic [`TMR0_DATA_W-1:0] i_s_axi_wdata,
    input  wire logic [3:0]              i_s_axi_wstrb,
    // AXI4-Lite write response
    output logic                         o_s_axi_bvalid,
    input  wire logic                    i_s_axi_bready,
    output logic [1:0]                   o_s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic                    i_s_axi_arvalid,
    output logic                         o_s_axi_arready,
    input  wire logic [`TMR0_ADDR_W-1:0] i_s_axi_araddr,
    input  wire logic [2:0]              i_s_axi_arprot,
    // AXI4-Lite read data
    output logic                         o_s_axi_rvalid,
    input  wire logic                    i_s_axi_rready,
    output logic [`TMR0_DATA_W-1:0]      o_s_axi_rdata,
    output logic [1:0]                   o_s_axi_rresp,
    // External count pin
    input  wire logic                    i_external_count_pin,
    // Interrupt
    output logic                         o_irq
);
    import tmr0_pkg::*;

    // Prescaler taps.
    tmr0_taps_t taps;

    tmr0_prescaler #(
        .W      (`TMR0_PRESC_W)
    ) tmr0_prescaler_i (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .o_taps (taps)
    );

    // Count pin synchroniser and edge history.
    logic pin_sync1_reg;
    logic pin_sync2_reg;
    logic pin_prev_reg;
    logic pin_rise;
    logic pin_fall;

    // Only the second stage and the history flop are looked at by the edge logic.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pin_sync1_reg <= 1'b0;
            pin_sync2_reg <= 1'b0;
            pin_prev_reg  <= 1'b0;
        end else begin
            pin_sync1_reg <= i_external_count_pin;
            pin_sync2_reg <= pin_sync1_reg;
            pin_prev_reg  <= pin_sync2_reg;
        end
    end

    // The pin is read whatever its port direction, so software driving it also counts.
    always_comb begin
        pin_rise = pin_sync2_reg & ~pin_prev_reg;
        pin_fall = ~pin_sync2_reg & pin_prev_reg;
    end

    // Register and bus state.
    tmr0_clksel_t              ctrl_reg;
    tmr0_clksel_t              ctrl_next;
    logic [`TMR0_CNT_W-1:0]    cnt_reg;
    logic [`TMR0_CNT_W-1:0]    cnt_next;
    logic [`TMR0_EVT_W-1:0]    flag_reg;
    logic [`TMR0_EVT_W-1:0]    flag_next;
    logic [`TMR0_EVT_W-1:0]    mask_reg;
    logic [`TMR0_EVT_W-1:0]    mask_next;
    logic                      irq_reg;
    logic                      irq_next;

    logic                      aw_held_reg;
    logic                      aw_held_next;
    logic [`TMR0_IDX_W-1:0]    aw_idx_reg;
    logic [`TMR0_IDX_W-1:0]    aw_idx_next;
    logic                      w_held_reg;
    logic                      w_held_next;
    logic [`TMR0_DATA_W-1:0]   wdata_reg;
    logic [`TMR0_DATA_W-1:0]   wdata_next;
    logic                      wlane0_reg;
    logic                      wlane0_next;
    logic                      bvalid_reg;
    logic                      bvalid_next;
    logic [1:0]                bresp_reg;
    logic [1:0]                bresp_next;
    logic                      awready_reg;
    logic                      awready_next;
    logic                      wready_reg;
    logic                      wready_next;
    logic                      arready_reg;
    logic                      arready_next;
    logic                      rvalid_reg;
    logic                      rvalid_next;
    logic [`TMR0_DATA_W-1:0]   rdata_reg;
    logic [`TMR0_DATA_W-1:0]   rdata_next;
    logic [1:0]                rresp_reg;
    logic [1:0]                rresp_next;

    logic                      wr_fire;
    logic                      wr_cnt;
    logic                      tick;
    logic                      ovf;
    logic [`TMR0_IDX_W-1:0]    ar_idx;
    logic [`TMR0_EVT_W-1:0]    flag_clr;

    // Count enable from the clock select field.
    always_comb begin
        case (ctrl_reg)
            TMR0_CS_STOP:     tick = 1'b0;
            TMR0_CS_CLK:      tick = 1'b1;
            TMR0_CS_DIV8:     tick = taps.tap8;
            TMR0_CS_DIV64:    tick = taps.tap64;
            TMR0_CS_DIV256:   tick = taps.tap256;
            TMR0_CS_DIV1024:  tick = taps.tap1024;
            TMR0_CS_PIN_FALL: tick = pin_fall;
            TMR0_CS_PIN_RISE: tick = pin_rise;
            default:          tick = 1'b0;
        endcase
    end

    // Write channel: address and data are taken in either order, then applied together.
    always_comb begin
        aw_held_next = aw_held_reg;
        aw_idx_next  = aw_idx_reg;
        w_held_next  = w_held_reg;
        wdata_next   = wdata_reg;
        wlane0_next  = wlane0_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        wr_fire      = aw_held_reg & w_held_reg & ~bvalid_reg;
        if (i_s_axi_awvalid && awready_reg) begin
            aw_held_next = 1'b1;
            aw_idx_next  = i_s_axi_awaddr[`TMR0_ADDR_W-1:2];
        end
        if (i_s_axi_wvalid && wready_reg) begin
            w_held_next = 1'b1;
            wdata_next  = i_s_axi_wdata;
            wlane0_next = i_s_axi_wstrb[0];
        end
        if (bvalid_reg && i_s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (wr_fire) begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            case (aw_idx_reg)
                `TMR0_CNT_IDX, `TMR0_CTRL_IDX, `TMR0_FLAG_IDX, `TMR0_MASK_IDX: bresp_next = `TMR0_RESP_OKAY;
                default: bresp_next = `TMR0_RESP_SLVERR;
            endcase
        end
        awready_next = ~aw_held_next;
        wready_next  = ~w_held_next;
    end

    // Byte lane 0 carries every register; other lanes are ignored.
    always_comb begin
        wr_cnt    = wr_fire & wlane0_reg & (aw_idx_reg == `TMR0_CNT_IDX);
        ctrl_next = ctrl_reg;
        mask_next = mask_reg;
        flag_clr  = `TMR0_EVT_RST;
        if (wr_fire && wlane0_reg) begin
            case (aw_idx_reg)
                `TMR0_CTRL_IDX: ctrl_next = tmr0_clksel_t'(wdata_reg[`TMR0_CTRL_W-1:0]);
                `TMR0_MASK_IDX: mask_next = wdata_reg[`TMR0_EVT_W-1:0];
                `TMR0_FLAG_IDX: flag_clr  = wdata_reg[`TMR0_EVT_W-1:0];
                default:      ctrl_next = ctrl_reg;
            endcase
        end
    end

    // A software write owns the counter for its cycle; counting goes on from the written value after it.
    always_comb begin
        ovf = 1'b0;
        if (wr_cnt) begin
            cnt_next = wdata_reg[`TMR0_CNT_W-1:0];
        end else if (tick) begin
            cnt_next = cnt_reg + {{(`TMR0_CNT_W-1){1'b0}}, 1'b1};
            ovf      = (cnt_reg == `TMR0_CNT_MAX);
        end else begin
            cnt_next = cnt_reg;
        end
    end

    // The overflow event wins over a clear arriving in the same cycle.
    always_comb begin
        flag_next = flag_reg & ~flag_clr;
        if (ovf) begin
            flag_next[`TMR0_OVF_BIT] = 1'b1;
        end
        irq_next = |(flag_next & mask_next);
    end

    // Read channel: the word is captured at acceptance and held until taken.
    always_comb begin
        ar_idx       = i_s_axi_araddr[`TMR0_ADDR_W-1:2];
        arready_next = arready_reg;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        if (rvalid_reg && i_s_axi_rready) begin
            rvalid_next  = 1'b0;
            arready_next = 1'b1;
        end
        if (i_s_axi_arvalid && arready_reg) begin
            arready_next = 1'b0;
            rvalid_next  = 1'b1;
            rresp_next   = `TMR0_RESP_OKAY;
            case (ar_idx)
                `TMR0_CNT_IDX:  rdata_next = {{(`TMR0_DATA_W-`TMR0_CNT_W){1'b0}}, cnt_reg};
                `TMR0_CTRL_IDX: rdata_next = {{(`TMR0_DATA_W-`TMR0_CTRL_W){1'b0}}, ctrl_reg};
                `TMR0_FLAG_IDX: rdata_next = {{(`TMR0_DATA_W-`TMR0_EVT_W){1'b0}}, flag_reg};
                `TMR0_MASK_IDX: rdata_next = {{(`TMR0_DATA_W-`TMR0_EVT_W){1'b0}}, mask_reg};
                default: begin
                    rdata_next = '0;
                    rresp_next = `TMR0_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_reg    <= TMR0_CS_STOP;
            cnt_reg     <= `TMR0_CNT_RST;
            flag_reg    <= `TMR0_EVT_RST;
            mask_reg    <= `TMR0_EVT_RST;
            irq_reg     <= 1'b0;
            aw_held_reg <= 1'b0;
            aw_idx_reg  <= '0;
            w_held_reg  <= 1'b0;
            wdata_reg   <= '0;
            wlane0_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `TMR0_RESP_OKAY;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= '0;
            rresp_reg   <= `TMR0_RESP_OKAY;
        end else begin
            ctrl_reg    <= ctrl_next;
            cnt_reg     <= cnt_next;
            flag_reg    <= flag_next;
            mask_reg    <= mask_next;
            irq_reg     <= irq_next;
            aw_held_reg <= aw_held_next;
            aw_idx_reg  <= aw_idx_next;
            w_held_reg  <= w_held_next;
            wdata_reg   <= wdata_next;
            wlane0_reg  <= wlane0_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            awready_reg <= awready_next;
            wready_reg  <= wready_next;
            arready_reg <= arready_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
        end
    end

    // Outputs straight from flops; protection bits carry no meaning here.
    always_comb begin
        o_s_axi_awready = awready_reg;
        o_s_axi_wready  = wready_reg;
        o_s_axi_bvalid  = bvalid_reg;
        o_s_axi_bresp   = bresp_reg;
        o_s_axi_arready = arready_reg;
        o_s_axi_rvalid  = rvalid_reg;
        o_s_axi_rdata   = rdata_reg;
        o_s_axi_rresp   = rresp_reg;
        o_irq           = irq_reg;
    end

endmodule : tmr0_top

`default_nettype wire

// file: testbench/tmr0_properties.sv
// Concurrent checks on the register port and interrupt output of the timer.
// Assumes it is bound to tmr0_top and sees only that module's ports.
`include "tmr0_consts.svh"
`default_nettype none

module tmr0_properties (
    // Clock and reset
    input wire logic                  i_clk,
    input wire logic                  i_nrst,
    // Register bus
    input wire logic                  i_s_axi_awvalid,
    input wire logic                  o_s_axi_awready,
    input wire logic                  i_s_axi_wvalid,
    input wire logic                  o_s_axi_wready,
    input wire logic                  o_s_axi_bvalid,
    input wire logic                  i_s_axi_bready,
    input wire logic [1:0]            o_s_axi_bresp,
    input wire logic                  i_s_axi_arvalid,
    input wire logic                  o_s_axi_arready,
    input wire logic [`TMR0_ADDR_W-1:0] i_s_axi_araddr,
    input wire logic                  o_s_axi_rvalid,
    input wire logic                  i_s_axi_rready,
    input wire logic [`TMR0_DATA_W-1:0] o_s_axi_rdata,
    input wire logic [1:0]            o_s_axi_rresp,
    // Interrupt
    input wire logic                  o_irq
);
    logic [`TMR0_ADDR_W-1:0] ar_reg;
    logic                  known;

    // Remembers the address of the read under way.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ar_reg <= '0;
        end else if (i_s_axi_arvalid && o_s_axi_arready) begin
            ar_reg <= i_s_axi_araddr;
        end
    end
    assign known = ar_reg inside {{`TMR0_CNT_IDX, 2'h0}, {`TMR0_CTRL_IDX, 2'h0}, {`TMR0_FLAG_IDX, 2'h0},
                                  {`TMR0_MASK_IDX, 2'h0}};

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    a_write_answer: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
        |-> ##2 o_s_axi_bvalid) else $error("write answer late");
    a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
        else $error("read answer late");
    a_read_holds: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
        else $error("read data dropped");
    a_resp_holds: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
        else $error("write response dropped");
    a_read_blocked: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
        else $error("second read taken");
    a_ctrl_high_zero: assert property (o_s_axi_rvalid && ar_reg == {`TMR0_CTRL_IDX, 2'h0}
        |-> o_s_axi_rdata[31:3] == '0) else $error("control upper bits set");
    a_count_width: assert property (o_s_axi_rvalid && ar_reg == {`TMR0_CNT_IDX, 2'h0}
        |-> o_s_axi_rdata[31:8] == '0) else $error("count wider than eight bits");
    a_unmapped_read: assert property (o_s_axi_rvalid && !known
        |-> o_s_axi_rresp == `TMR0_RESP_SLVERR && o_s_axi_rdata == '0) else $error("unmapped read answered");
    a_irq_fall_write: assert property ($fell(o_irq) |-> $rose(o_s_axi_bvalid))
        else $error("interrupt fell without a write");

    c_irq: cover property ($rose(o_irq));
    c_unmapped: cover property (o_s_axi_rvalid && !known);
    c_write_done: cover property (o_s_axi_bvalid && i_s_axi_bready);
endmodule : tmr0_properties

bind tmr0_top tmr0_properties tmr0_properties_i (.*);

`default_nettype wire

// file: testbench/tmr0_pin_src.sv
// Model of the external source that toggles the count pin.
// Assumes the bench calls pulses() right after a rising clock edge.
`default_nettype none

module tmr0_pin_src (
    // Clock
    input  wire logic i_clk,
    // Count pin
    output logic      o_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    initial o_pin = 1'b0;

    // Each level stands two clocks, so no edge can slip between samples.
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge i_clk);
            o_pin <= 1'b1;
            repeat (2) @(posedge i_clk);
            o_pin <= 1'b0;
            @(posedge i_clk);
        end
    endtask : pulses
endmodule : tmr0_pin_src

`default_nettype wire

// file: testbench/tmr0_top_bench.sv
// Self-checking bench for the timer: register access, clock selects, overflow interrupt.
// Assumes the design and the pin source model are compiled before it.
`include "tmr0_consts.svh"
`default_nettype none

module tmr0_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import tmr0_pkg::*;

    logic        i_clk, i_nrst, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid;
    logic        i_s_axi_rready, i_external_count_pin, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
    logic        o_s_axi_arready, o_s_axi_rvalid, o_irq;
    logic [9:0]  i_s_axi_awaddr, i_s_axi_araddr;
    logic [2:0]  i_s_axi_awprot, i_s_axi_arprot;
    logic [3:0]  i_s_axi_wstrb;
    logic [1:0]  o_s_axi_bresp, o_s_axi_rresp;
    logic [31:0] i_s_axi_wdata, o_s_axi_rdata, v0, v1;
    int          bad_count, samples_checked, cyc, t_start, t_end;
    localparam logic [1:0] OK = `TMR0_RESP_OKAY;
    localparam logic [1:0] ERR = `TMR0_RESP_SLVERR;
    localparam int SH [6] = '{0, 0, `TMR0_TAP8_BITS, `TMR0_TAP64_BITS, `TMR0_TAP256_BITS, `TMR0_TAP1024_BITS};

    tmr0_top tmr0_top_i (.*);
    tmr0_pin_src tmr0_pin_src_i (.i_clk(i_clk), .o_pin(i_external_count_pin));

    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    always @(posedge i_clk) cyc <= cyc + 1;

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge i_clk);
        i_s_axi_awaddr <= {idx, 2'h0};
        i_s_axi_wdata <= d;
        i_s_axi_awvalid <= 1'b1;
        i_s_axi_wvalid <= 1'b1;
        i_s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge i_clk);
            if (i_s_axi_awvalid && o_s_axi_awready) begin
                aw_ok = 1'b1;
                i_s_axi_awvalid <= 1'b0;
            end
            if (i_s_axi_wvalid && o_s_axi_wready) begin
                w_ok = 1'b1;
                i_s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge i_clk); while (!o_s_axi_bvalid);
        i_s_axi_bready <= 1'b0;
        chk("bresp", o_s_axi_bresp, er);
    endtask : wr

    task automatic rd(input logic [7:0] idx, output logic [31:0] d, output int t, input logic [1:0] er);
        @(posedge i_clk);
        i_s_axi_araddr <= {idx, 2'h0};
        i_s_axi_arvalid <= 1'b1;
        i_s_axi_rready <= 1'b1;
        do @(posedge i_clk); while (!o_s_axi_arready);
        i_s_axi_arvalid <= 1'b0;
        t = cyc;
        do @(posedge i_clk); while (!o_s_axi_rvalid);
        d = o_s_axi_rdata;
        i_s_axi_rready <= 1'b0;
        chk("rresp", o_s_axi_rresp, er);
    endtask : rd

    task automatic rd_is(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        int t;
        rd(idx, d, t, er);
        chk("rdata", d, exp);
    endtask : rd_is

    initial begin
        {i_nrst, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready} = '0;
        {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_awprot, i_s_axi_arprot, i_s_axi_wdata} = '0;
        i_s_axi_wstrb = 4'hf;
        cyc = 0;
        repeat (5) @(posedge i_clk);
        i_nrst <= 1'b1;
        rd_is(`TMR0_CNT_IDX, 32'h0, OK);
        rd_is(`TMR0_CTRL_IDX, 32'h0, OK);
        rd_is(`TMR0_FLAG_IDX, 32'h0, OK);
        wr(`TMR0_CTRL_IDX, 32'hffffffff, OK);
        rd_is(`TMR0_CTRL_IDX, 32'h7, OK);
        wr(`TMR0_CTRL_IDX, TMR0_CS_STOP, OK);
        wr(`TMR0_CNT_IDX, 32'ha5, OK);
        repeat (20) @(posedge i_clk);
        rd_is(`TMR0_CNT_IDX, 32'ha5, OK);
        // A write without byte lane 0 must leave the count alone.
        i_s_axi_wstrb <= 4'he;
        wr(`TMR0_CNT_IDX, 32'h11, OK);
        i_s_axi_wstrb <= 4'hf;
        rd_is(`TMR0_CNT_IDX, 32'ha5, OK);
        // Late rready: the read answer has to stand until it is taken.
        i_s_axi_araddr <= {`TMR0_CTRL_IDX, 2'h0};
        i_s_axi_arvalid <= 1'b1;
        do @(posedge i_clk); while (!o_s_axi_arready);
        i_s_axi_arvalid <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_s_axi_rready <= 1'b1;
        do @(posedge i_clk); while (!o_s_axi_rvalid);
        i_s_axi_rready <= 1'b0;
        chk("late rdata", o_s_axi_rdata, 32'h0);
        wr(8'hff, 32'h1, ERR);
        rd_is(8'hff, 32'h0, ERR);
        // Spans are whole multiples of each divider, so the tick count is exact.
        for (int s = 1; s <= 5; s++) begin
            wr(`TMR0_CTRL_IDX, s, OK);
            rd(`TMR0_CNT_IDX, v0, t_start, OK);
            while (cyc != t_start + (s == 1 ? 100 : 1024) - 2) @(posedge i_clk);
            rd(`TMR0_CNT_IDX, v1, t_end, OK);
            chk("span", t_end - t_start, s == 1 ? 100 : 1024);
            chk("ticks", v1, (v0 + ((s == 1 ? 100 : 1024) >> SH[s])) & 32'hff);
        end
        for (int s = 6; s <= 7; s++) begin
            wr(`TMR0_CTRL_IDX, s, OK);
            rd(`TMR0_CNT_IDX, v0, t_start, OK);
            tmr0_pin_src_i.pulses(5);
            repeat (5) @(posedge i_clk);
            rd(`TMR0_CNT_IDX, v1, t_end, OK);
            chk("pin count", v1, (v0 + 5) & 32'hff);
        end
        wr(`TMR0_CTRL_IDX, TMR0_CS_CLK, OK);
        wr(`TMR0_CNT_IDX, 32'h40, OK);
        rd_is(`TMR0_CNT_IDX, 32'h42, OK);
        wr(`TMR0_CTRL_IDX, TMR0_CS_STOP, OK);
        wr(`TMR0_FLAG_IDX, 32'h1, OK);
        wr(`TMR0_CNT_IDX, 32'hff, OK);
        wr(`TMR0_MASK_IDX, 32'h1, OK);
        chk("irq idle", o_irq, 1'b0);
        wr(`TMR0_CTRL_IDX, TMR0_CS_CLK, OK);
        wr(`TMR0_CTRL_IDX, TMR0_CS_STOP, OK);
        chk("irq wrap", o_irq, 1'b1);
        rd_is(`TMR0_FLAG_IDX, 32'h1, OK);
        wr(`TMR0_MASK_IDX, 32'h0, OK);
        chk("irq masked", o_irq, 1'b0);
        wr(`TMR0_MASK_IDX, 32'h1, OK);
        chk("irq unmasked", o_irq, 1'b1);
        wr(`TMR0_FLAG_IDX, 32'h1, OK);
        chk("irq cleared", o_irq, 1'b0);
        rd_is(`TMR0_FLAG_IDX, 32'h0, OK);
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        $display("watchdog expired");
        give_verdict();
    end
endmodule : tmr0_top_bench

`default_nettype wire
